// >>> mdu_defs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * multiply/divide unit. Assumes a 32-bit classic Wishbone slave, byte address.
 */
`ifndef MDU_DEFS_SVH
`define MDU_DEFS_SVH

`define MDU_OFS_OPERAND_0 8'h00
`define MDU_OFS_OPERAND_1 8'h04
`define MDU_OFS_OPERAND_2 8'h08
`define MDU_OFS_OPERAND_3 8'h0C
`define MDU_OFS_OPERAND_4 8'h10
`define MDU_OFS_OPERAND_5 8'h14
`define MDU_OFS_FLAGS 8'h18
`define MDU_OFS_IRQ_STATUS 8'h1C
`define MDU_OFS_IRQ_MASK 8'h20

`define MDU_BIT_SEQ_ERR 7
`define MDU_BIT_OVERFLOW 6

`define MDU_IRQ_DONE 0
`define MDU_IRQ_SEQ_ERR 1
`define MDU_IRQ_W 2

`define MDU_CYC_DIV32 5'h11
`define MDU_CYC_DIV16 5'h09
`define MDU_CYC_MUL 5'h0B

`define MDU_RST_BYTE 8'h00
`define MDU_RST_IRQ 2'h0

`endif

// >>> mdu_pkg.sv
/*
 * Types of the multiply/divide unit. Assumes mdu_defs.svh alongside.
 */
package mdu_pkg;
    // Write order tracker: which operand write is expected next.
    typedef enum logic [3:0] {
        MDU_SEQ_IDLE,
        MDU_SEQ_W0,
        MDU_SEQ_W01,
        MDU_SEQ_W012,
        MDU_SEQ_W0123,
        MDU_SEQ_W01234,
        MDU_SEQ_W014,
        MDU_SEQ_W04,
        MDU_SEQ_W041
    } mdu_seq_e;

    typedef enum logic [1:0] {
        MDU_OP_DIV32,
        MDU_OP_DIV16,
        MDU_OP_MUL
    } mdu_op_e;
endpackage : mdu_pkg

// >>> mdu_core.sv
/*
 * Multiply/divide unit with a classic Wishbone slave port.
 * Assumes a single clock domain, synchronous active-high reset and a master
 * that keeps one request steady until it sees ack.
 */
`timescale 1ns/10ps
`default_nettype none
`include "mdu_defs.svh"

module mdu_core
    import mdu_pkg::*;
#(
    parameter int ADDR_W = 8 // Wishbone byte address width.
) (
    input wire logic clk_i, // System clock, 20 MHz.
    input wire logic rst_i, // Synchronous reset, active high.
    input wire logic ce_i, // Clock enable; low freezes all state.
    input wire logic [ADDR_W-1:0] wb_adr_i, // Byte address.
    input wire logic [31:0] wb_dat_i, // Write data.
    input wire logic [3:0] wb_sel_i, // Byte enables.
    input wire logic wb_we_i, // Write enable.
    input wire logic wb_cyc_i, // Bus cycle.
    input wire logic wb_stb_i, // Strobe.
    output logic [31:0] wb_dat_o, // Read data, registered.
    output logic wb_ack_o, // Acknowledge, one cycle.
    output logic busy_o, // Computation in progress.
    output logic irq_o // Level interrupt.
);

    logic [7:0] opr_r [0:5];
    logic [7:0] opr_nxt [0:5];
    mdu_seq_e seq_r, seq_nxt;
    mdu_op_e op_r, op_nxt;
    logic busy_r, busy_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic err_r, err_nxt;
    logic ovf_r, ovf_nxt;
    logic [`MDU_IRQ_W-1:0] ists_r, ists_nxt;
    logic [`MDU_IRQ_W-1:0] imask_r, imask_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic ack_r, ack_nxt;
    logic irq_r, irq_nxt;

    logic req;
    logic [2:0] opr_sel;
    logic opr_hit;
    logic wr_byte;
    logic [7:0] wr_val;
    logic [31:0] dividend;
    logic [15:0] divisor;
    logic [31:0] quot;
    logic [15:0] rem;
    logic [31:0] prod;

    // A new access is taken only in the cycle where ack is not already out.
    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr_byte = wb_we_i && wb_sel_i[0];
    assign wr_val = wb_dat_i[7:0];

    always_comb begin
        opr_hit = 1'b1;
        opr_sel = 3'h0;
        if (wb_adr_i == ADDR_W'(`MDU_OFS_OPERAND_0)) begin
            opr_sel = 3'h0;
        end else if (wb_adr_i == ADDR_W'(`MDU_OFS_OPERAND_1)) begin
            opr_sel = 3'h1;
        end else if (wb_adr_i == ADDR_W'(`MDU_OFS_OPERAND_2)) begin
            opr_sel = 3'h2;
        end else if (wb_adr_i == ADDR_W'(`MDU_OFS_OPERAND_3)) begin
            opr_sel = 3'h3;
        end else if (wb_adr_i == ADDR_W'(`MDU_OFS_OPERAND_4)) begin
            opr_sel = 3'h4;
        end else if (wb_adr_i == ADDR_W'(`MDU_OFS_OPERAND_5)) begin
            opr_sel = 3'h5;
        end else begin
            opr_hit = 1'b0;
        end
    end

    // Operands are held in the byte registers; the arithmetic is combinational and
    // results are loaded only at the documented completion cycle, so the
    // latency seen by software matches the fixed figures.
    always_comb begin
        dividend = {opr_r[3], opr_r[2], opr_r[1], opr_r[0]};
        if (op_r == MDU_OP_DIV16) begin
            dividend = {16'h0000, opr_r[1], opr_r[0]};
        end
        divisor = {opr_r[5], opr_r[4]};
        quot = 32'h0000_0000;
        rem = 16'h0000;
        if (divisor != 16'h0000) begin
            quot = dividend / {16'h0000, divisor};
            rem = 16'(dividend % {16'h0000, divisor});
        end
        prod = {16'h0000, opr_r[1], opr_r[0]} * {16'h0000, opr_r[5], opr_r[4]};
    end

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            opr_nxt[i] = opr_r[i];
        end
        seq_nxt = seq_r;
        op_nxt = op_r;
        busy_nxt = busy_r;
        cnt_nxt = cnt_r;
        err_nxt = err_r;
        ovf_nxt = ovf_r;
        ists_nxt = ists_r;
        imask_nxt = imask_r;
        dat_nxt = dat_r;
        ack_nxt = 1'b0;
        if (busy_r) begin
            cnt_nxt = cnt_r - 5'h01;
            if (cnt_r == 5'h01) begin
                busy_nxt = 1'b0;
                ists_nxt[`MDU_IRQ_DONE] = 1'b1;
                seq_nxt = MDU_SEQ_IDLE;
                if (op_r == MDU_OP_MUL) begin
                    {opr_nxt[3], opr_nxt[2], opr_nxt[1], opr_nxt[0]} = prod;
                    ovf_nxt = (prod[31:16] != 16'h0000);
                end else begin
                    {opr_nxt[3], opr_nxt[2], opr_nxt[1], opr_nxt[0]} = quot;
                    {opr_nxt[5], opr_nxt[4]} = rem;
                    ovf_nxt = (divisor == 16'h0000);
                end
            end
        end
        if (req) begin
            ack_nxt = 1'b1;
            dat_nxt = 32'h0000_0000;
            if (opr_hit) begin
                if (!wb_we_i) begin
                    dat_nxt = {24'h000000, opr_r[opr_sel]};
                end
                if (busy_r) begin
                    err_nxt = 1'b1;
                    ists_nxt[`MDU_IRQ_SEQ_ERR] = 1'b1;
                end else if (wr_byte) begin
                    opr_nxt[opr_sel] = wr_val;
                    // Only operand writes move the tracker; other traffic is ignored.
                    case (seq_r)
                        MDU_SEQ_IDLE: seq_nxt = (opr_sel == 3'h0) ? MDU_SEQ_W0 : MDU_SEQ_IDLE;
                        MDU_SEQ_W0: seq_nxt = (opr_sel == 3'h1) ? MDU_SEQ_W01 :
                                              (opr_sel == 3'h4) ? MDU_SEQ_W04 : MDU_SEQ_IDLE;
                        MDU_SEQ_W01: seq_nxt = (opr_sel == 3'h2) ? MDU_SEQ_W012 :
                                               (opr_sel == 3'h4) ? MDU_SEQ_W014 : MDU_SEQ_IDLE;
                        MDU_SEQ_W012: seq_nxt = (opr_sel == 3'h3) ? MDU_SEQ_W0123 : MDU_SEQ_IDLE;
                        MDU_SEQ_W0123: seq_nxt = (opr_sel == 3'h4) ? MDU_SEQ_W01234 : MDU_SEQ_IDLE;
                        MDU_SEQ_W04: seq_nxt = (opr_sel == 3'h1) ? MDU_SEQ_W041 : MDU_SEQ_IDLE;
                        default: seq_nxt = MDU_SEQ_IDLE;
                    endcase
                    // A write to register 0 from any state other than idle also
                    // restarts, so a fresh order can begin without a dead write.
                    if (opr_sel == 3'h0) begin
                        seq_nxt = MDU_SEQ_W0;
                    end
                    if (opr_sel == 3'h5) begin
                        seq_nxt = MDU_SEQ_IDLE;
                        if (seq_r == MDU_SEQ_W01234 || seq_r == MDU_SEQ_W014 ||
                            seq_r == MDU_SEQ_W041) begin
                            busy_nxt = 1'b1;
                        end
                        case (seq_r)
                            MDU_SEQ_W01234: begin
                                op_nxt = MDU_OP_DIV32;
                                cnt_nxt = `MDU_CYC_DIV32;
                            end
                            MDU_SEQ_W014: begin
                                op_nxt = MDU_OP_DIV16;
                                cnt_nxt = `MDU_CYC_DIV16;
                            end
                            MDU_SEQ_W041: begin
                                op_nxt = MDU_OP_MUL;
                                cnt_nxt = `MDU_CYC_MUL;
                            end
                            default: cnt_nxt = cnt_r;
                        endcase
                    end
                end
            end else if (wb_adr_i == ADDR_W'(`MDU_OFS_FLAGS)) begin
                if (!wb_we_i) begin
                    dat_nxt[`MDU_BIT_SEQ_ERR] = err_nxt;
                    dat_nxt[`MDU_BIT_OVERFLOW] = ovf_r;
                    // A read while busy skips the clear and leaves the flag set; an error raised in this cycle wins.
                    if (!busy_r) begin
                        err_nxt = 1'b0;
                    end
                end
            end else if (wb_adr_i == ADDR_W'(`MDU_OFS_IRQ_STATUS)) begin
                if (!wb_we_i) begin
                    dat_nxt[`MDU_IRQ_W-1:0] = ists_r;
                    // Bits newly set by an event in this same cycle survive the clear.
                    ists_nxt = ists_nxt & ~ists_r;
                end
            end else if (wb_adr_i == ADDR_W'(`MDU_OFS_IRQ_MASK)) begin
                if (!wb_we_i) begin
                    dat_nxt[`MDU_IRQ_W-1:0] = imask_r;
                end else if (wb_sel_i[0]) begin
                    imask_nxt = wb_dat_i[`MDU_IRQ_W-1:0];
                end
            end
        end
        irq_nxt = |(ists_nxt & imask_nxt);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 6; i++) begin
                opr_r[i] <= `MDU_RST_BYTE;
            end
            seq_r <= MDU_SEQ_IDLE;
            op_r <= MDU_OP_DIV32;
            busy_r <= 1'b0;
            cnt_r <= 5'h00;
            err_r <= 1'b0;
            ovf_r <= 1'b0;
            ists_r <= `MDU_RST_IRQ;
            imask_r <= `MDU_RST_IRQ;
            dat_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (ce_i) begin
            for (int i = 0; i < 6; i++) begin
                opr_r[i] <= opr_nxt[i];
            end
            seq_r <= seq_nxt;
            op_r <= op_nxt;
            busy_r <= busy_nxt;
            cnt_r <= cnt_nxt;
            err_r <= err_nxt;
            ovf_r <= ovf_nxt;
            ists_r <= ists_nxt;
            imask_r <= imask_nxt;
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign busy_o = busy_r;
    assign irq_o = irq_r;

endmodule // mdu_core
`default_nettype wire

// >>> mdu_chk.sv
/* Port checker for mdu_core, bound from tb_top.
   Assumes one clock domain and ce_i held high. */
`timescale 1ns/10ps
`default_nettype none
`include "mdu_defs.svh"
module mdu_chk #(
    parameter int ADDR_W = 8 // Address width.
) (
    input wire logic clk_i, // Clock.
    input wire logic rst_i, // Reset.
    input wire logic ce_i, // Enable.
    input wire logic [ADDR_W-1:0] wb_adr_i, // Address.
    input wire logic wb_we_i, // Write.
    input wire logic wb_cyc_i, // Cycle.
    input wire logic wb_stb_i, // Strobe.
    input wire logic [31:0] wb_dat_o, // Read data.
    input wire logic wb_ack_o, // Acknowledge.
    input wire logic busy_o // Busy.
);
    // Busy cycles are counted so that the latency check needs no long repetition.
    logic [4:0] cnt_r, cnt_nxt;
    logic flag_rd;
    assign flag_rd = wb_ack_o && !wb_we_i && wb_adr_i == `MDU_OFS_FLAGS;
    always_comb cnt_nxt = busy_o ? cnt_r + 5'h01 : 5'h00;
    always_ff @(posedge clk_i) cnt_r <= rst_i ? 5'h00 : cnt_nxt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o) else $error("No ack.");
    chk_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("Ack too long.");
    chk_ack_cause: assert property (
        wb_ack_o |-> $past(wb_stb_i)) else $error("Ack without strobe.");
    chk_busy_start: assert property (
        $rose(busy_o) |-> wb_ack_o && wb_we_i && wb_adr_i == `MDU_OFS_OPERAND_5)
        else $error("Busy without start.");
    chk_busy_len: assert property (
        $fell(busy_o) |-> cnt_r inside {`MDU_CYC_DIV32, `MDU_CYC_DIV16, `MDU_CYC_MUL})
        else $error("Wrong latency.");
    chk_busy_min: assert property (
        $rose(busy_o) |-> busy_o [*8]) else $error("Busy too short.");
    chk_busy_gap: assert property (
        $fell(busy_o) |-> !busy_o [*2]) else $error("Restart without sequence.");
    chk_flags_zero: assert property (
        flag_rd |-> wb_dat_o[31:8] == 24'h000000 && wb_dat_o[5:0] == 6'h00)
        else $error("Flags unused bits set.");
    cover property ($fell(busy_o) && cnt_r == `MDU_CYC_DIV32);
    cover property ($fell(busy_o) && cnt_r == `MDU_CYC_DIV16);
    cover property ($fell(busy_o) && cnt_r == `MDU_CYC_MUL);
endmodule // mdu_chk
`default_nettype wire

// >>> tb_top.sv
/* Self-checking bench for mdu_core with a reference model of the unit.
   Assumes the design files and mdu_chk.sv are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "mdu_defs.svh"
module tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rd, dat_o;
    logic ack, busy, irq;
    int error_cnt = 0, checked = 0, cyc_cnt = 0;
    always #25 clk_i = ~clk_i;
    // The enable stays high: the unit is never put to sleep while computing.
    mdu_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .busy_o(busy), .irq_o(irq));
    task automatic results;
        if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // The request stands until ack is seen at an edge; a missing ack counts as a mismatch.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) error_cnt++;
    endtask
    // Operand byte k of every operation is byte k of {b, a}, so one table of orders serves.
    task automatic run(input int op, input logic [31:0] a, input logic [15:0] b,
        input logic hit, input logic pre, input logic [1:0] m);
        int ord[3][6] = '{'{0, 1, 2, 3, 4, 5}, '{0, 1, 4, 5, 0, 0}, '{0, 4, 1, 5, 0, 0}};
        logic [31:0] q, r;
        logic ov;
        bus(1'b1, `MDU_OFS_IRQ_MASK, {6'h00, m});
        if (pre) bus(1'b1, `MDU_OFS_OPERAND_0, 8'h5A);
        if (pre) bus(1'b1, `MDU_OFS_OPERAND_4, 8'hA5);
        for (int i = 0; i < (op == 0 ? 6 : 4); i++) begin
            if ($urandom % 2) bus(1'b0, 8'h40, 8'h00);
            bus(1'b1, 8'(4 * ord[op][i]), 8'({b, a} >> (8 * ord[op][i])));
        end
        cmp(busy, 32'h1);
        if (hit) bus(a[0], `MDU_OFS_OPERAND_1, 8'hEE);
        repeat (40) if (busy !== 1'b0) @(posedge clk_i);
        ov = op == 2 ? a[15:0] * b > 32'hFFFF : b == 16'h0000;
        q = op == 2 ? a[15:0] * b : ov ? 32'h0 : (op == 0 ? a : a[15:0]) / b;
        r = ov || op == 2 ? 32'h0 : (op == 0 ? a : a[15:0]) % b;
        bus(1'b0, `MDU_OFS_FLAGS, 8'h00);
        cmp(rd, {24'h0, hit, ov, 6'h00});
        bus(1'b0, `MDU_OFS_FLAGS, 8'h00);
        cmp(rd, {24'h0, 1'b0, ov, 6'h00});
        cmp(irq, 32'(|(m & {hit, 1'b1})));
        bus(1'b0, `MDU_OFS_IRQ_STATUS, 8'h00);
        cmp(rd, {30'h0, hit, 1'b1});
        for (int i = 0; i < (op == 2 ? 4 : 6); i++) begin
            if ($urandom % 2) bus(1'b0, `MDU_OFS_FLAGS, 8'h00);
            bus(1'b0, 8'(4 * i), 8'h00);
            cmp(rd, {24'h0, 8'({r[15:0], q} >> (8 * i))});
        end
        cmp(irq, 32'h0);
    endtask
    initial begin
        void'($urandom(86));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 10; k++) begin
            bus(1'b0, 8'(4 * k), 8'h00);
            cmp(rd, 32'h0);
        end
        for (int k = 0; k < 4; k++) bus(1'b1, 8'(k == 3 ? 20 : 4 * k), 8'h33);
        cmp(busy, 32'h0);
        run(0, 32'hFFFFFFFF, 16'h0001, 1'b0, 1'b0, 2'h1);
        run(2, 32'h0000FFFF, 16'h0001, 1'b1, 1'b0, 2'h2);
        run(2, 32'h0000FFFF, 16'hFFFF, 1'b0, 1'b1, 2'h3);
        for (int i = 0; i < 30; i++)
            run(i % 3, $urandom, i % 5 == 4 ? 16'h0 : i % 5 == 3 ? 16'($urandom % 4) :
                16'($urandom), 1'(i % 4 == 1), 1'(i % 7 == 2), 2'(i));
        results();
    end
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 8000) begin
            error_cnt++;
            results();
        end
    end
endmodule // tb_top
bind mdu_core mdu_chk #(.ADDR_W(ADDR_W)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o));
`default_nettype wire
